/* src/gpcr_pkg.sv */
// Purpose: constants and carriers of the gpio port register block
// Assumes: 32 pins, word registers on AHB-Lite
// Notes: status and mask offsets sit in the free gap below 0x700
// Overview of operation
// - writing one to drive-clear bits drives those pins low, zeros keep
// - drive-clear read returns the pin drive value register
// - drive-enable register, one bit per pin, resets zero, 1 means output
// - writing one to drive-enable-set bits makes those pins outputs
// - drive-enable set and clear reads return the drive-enable register
// - level-match record bit per pin notes its sense criterion was met
// - wake select 0 gives direct detect, 1 gives latched wake signal
// - 32 pad configs at base plus four times index, reset value two
// - drive field codes eight low/high strength and disconnect pairs
// - level-watch field 0 off, 2 senses high, 3 senses low
package gpcr_pkg;
  localparam logic [11:0] OFF_DRIVE_VAL   = 12'h504;
  localparam logic [11:0] OFF_DRIVE_SET   = 12'h508;
  localparam logic [11:0] OFF_DRIVE_CLR   = 12'h50C;
  localparam logic [11:0] OFF_SAMPLED     = 12'h510;
  localparam logic [11:0] OFF_DIR         = 12'h514;
  localparam logic [11:0] OFF_DIR_SET     = 12'h518;
  localparam logic [11:0] OFF_DIR_CLR     = 12'h51C;
  localparam logic [11:0] OFF_MATCH       = 12'h520;
  localparam logic [11:0] OFF_WAKE_SEL    = 12'h524;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h600;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h604;
  localparam logic [11:0] OFF_PAD_CFG     = 12'h700;
  localparam logic [11:0] OFF_PAD_CFG_END = 12'h77C;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [31:0] RST_PAD_CFG     = 32'h0000_0002;
  localparam int          CFG_DIR_BIT     = 0;
  localparam int          CFG_INDISC_BIT  = 1;
  localparam int          CFG_PULL_LSB    = 2;
  localparam int          CFG_DRIVE_LSB   = 8;
  localparam int          CFG_SENSE_LSB   = 16;
  localparam logic [1:0]  PULL_NONE       = 2'h0;
  localparam logic [1:0]  PULL_DOWN       = 2'h1;
  localparam logic [1:0]  PULL_UP         = 2'h3;
  localparam logic [1:0]  SENSE_OFF       = 2'h0;
  localparam logic [1:0]  SENSE_HIGH      = 2'h2;
  localparam logic [1:0]  SENSE_LOW       = 2'h3;
  localparam int          IRQ_WAKE_BIT    = 0;
  localparam int          IRQ_MATCH_BIT   = 1;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef enum logic [2:0] {
    DRV_S0S1 = 3'h0,
    DRV_H0S1 = 3'h1,
    DRV_S0H1 = 3'h2,
    DRV_H0H1 = 3'h3,
    DRV_D0S1 = 3'h4,
    DRV_D0H1 = 3'h5,
    DRV_S0D1 = 3'h6,
    DRV_H0D1 = 3'h7
  } gpcr_drive_e;

  typedef struct packed {
    logic [1:0]  sense;
    gpcr_drive_e drive;
    logic [1:0]  pull;
    logic        in_disc;
  } gpcr_cfg_s;

  typedef struct packed {
    logic        write;
    logic [11:0] addr;
  } gpcr_req_s;

  localparam gpcr_cfg_s RST_CFG = '{sense: 2'h0, drive: DRV_S0S1, pull: 2'h0, in_disc: 1'b1};
endpackage : gpcr_pkg

/* src/gpcr_top.sv */
// Purpose: gpio port registers for 32 pins behind an AHB-Lite slave
// Assumes: pad inputs synchronous to mclk_i; single word transfers
// Notes: reads take one wait state, writes none; response always OKAY
//
// Design decision made here: the AHB-Lite register port.
module gpcr_top #(
  parameter int NPIN = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  output logic [31:0]           hrdata_o,
  input  wire logic [NPIN-1:0]  pad_in_i,
  output logic [NPIN-1:0]       pad_out_o,
  output logic [NPIN-1:0]       pad_oe_o,
  output logic [NPIN-1:0]       pad_in_en_o,
  output logic [NPIN-1:0]       pad_hd0_o,
  output logic [NPIN-1:0]       pad_hd1_o,
  output logic [NPIN-1:0]       pad_pull_up_o,
  output logic [NPIN-1:0]       pad_pull_dn_o,
  output logic                  wake_o,
  output logic                  irq_o
);

  // register state
  logic [NPIN-1:0]       drive_val;
  logic [NPIN-1:0]       dir;
  logic [NPIN-1:0]       match_rec;
  logic                  wake_sel;
  logic [1:0]            irq_status;
  logic [1:0]            irq_mask;
  logic                  wake_q;
  gpcr_pkg::gpcr_cfg_s   cfg [NPIN];

  // bus state
  gpcr_pkg::gpcr_req_s   dp_req;
  logic                  dp_wr;
  logic                  dp_rd;
  logic                  rd_wait;
  logic [31:0]           rdata;

  logic [NPIN-1:0]       next_drive_val;
  logic [NPIN-1:0]       next_dir;
  logic [NPIN-1:0]       next_match_rec;
  logic                  next_wake_sel;
  logic [1:0]            next_irq_status;
  logic [1:0]            next_irq_mask;
  logic                  next_wake_q;
  gpcr_pkg::gpcr_cfg_s   next_cfg [NPIN];
  gpcr_pkg::gpcr_req_s   next_dp_req;
  logic                  next_dp_wr;
  logic                  next_dp_rd;
  logic                  next_rd_wait;
  logic [31:0]           next_rdata;

  logic [NPIN-1:0]       level;
  logic [NPIN-1:0]       detect;
  logic                  wake;
  logic                  addr_take;
  logic                  mask_wr;
  logic                  status_rd;

  // pad config window hit
  function automatic logic is_cfg(input logic [11:0] a);
    return a >= gpcr_pkg::OFF_PAD_CFG && a <= gpcr_pkg::OFF_PAD_CFG_END
           && a[1:0] == 2'h0;
  endfunction : is_cfg

  // pin index inside the config window
  function automatic logic [4:0] cfg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - gpcr_pkg::OFF_PAD_CFG;
    return d[6:2];
  endfunction : cfg_idx

  // config struct to register word
  function automatic logic [31:0] cfg_word(input gpcr_pkg::gpcr_cfg_s c,
                                           input logic d);
    logic [31:0] w;
    w = gpcr_pkg::RST_WORD;
    w[gpcr_pkg::CFG_DIR_BIT] = d;
    w[gpcr_pkg::CFG_INDISC_BIT] = c.in_disc;
    w[gpcr_pkg::CFG_PULL_LSB +: 2] = c.pull;
    w[gpcr_pkg::CFG_DRIVE_LSB +: 3] = c.drive;
    w[gpcr_pkg::CFG_SENSE_LSB +: 2] = c.sense;
    return w;
  endfunction : cfg_word

  // register word to config struct
  function automatic gpcr_pkg::gpcr_cfg_s word_cfg(input logic [31:0] w);
    gpcr_pkg::gpcr_cfg_s c;
    c.in_disc = w[gpcr_pkg::CFG_INDISC_BIT];
    c.pull = w[gpcr_pkg::CFG_PULL_LSB +: 2];
    c.drive = gpcr_pkg::gpcr_drive_e'(w[gpcr_pkg::CFG_DRIVE_LSB +: 3]);
    c.sense = w[gpcr_pkg::CFG_SENSE_LSB +: 2];
    return c;
  endfunction : word_cfg

  // level-watch criterion of one pin
  function automatic logic sense_hit(input logic [1:0] s, input logic lv);
    logic h;
    h = 1'b0;
    if (s == gpcr_pkg::SENSE_HIGH) begin
      h = lv;
    end else if (s == gpcr_pkg::SENSE_LOW) begin
      h = ~lv;
    end
    return h;
  endfunction : sense_hit

  // pad side: levels, detect, strength, pulls
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pad_in_en_o[i] = ~cfg[i].in_disc;
      level[i] = pad_in_i[i] & ~cfg[i].in_disc;
      detect[i] = sense_hit(cfg[i].sense, pad_in_i[i]);
      pad_out_o[i] = drive_val[i];
      pad_oe_o[i] = dir[i];
      pad_hd0_o[i] = 1'b0;
      pad_hd1_o[i] = 1'b0;
      unique case (cfg[i].drive)
        gpcr_pkg::DRV_S0S1: begin
        end
        gpcr_pkg::DRV_H0S1: begin
          pad_hd0_o[i] = 1'b1;
        end
        gpcr_pkg::DRV_S0H1: begin
          pad_hd1_o[i] = 1'b1;
        end
        gpcr_pkg::DRV_H0H1: begin
          pad_hd0_o[i] = 1'b1;
          pad_hd1_o[i] = 1'b1;
        end
        gpcr_pkg::DRV_D0S1: begin
          pad_oe_o[i] = dir[i] & drive_val[i];
        end
        gpcr_pkg::DRV_D0H1: begin
          pad_oe_o[i] = dir[i] & drive_val[i];
          pad_hd1_o[i] = 1'b1;
        end
        gpcr_pkg::DRV_S0D1: begin
          pad_oe_o[i] = dir[i] & ~drive_val[i];
        end
        gpcr_pkg::DRV_H0D1: begin
          pad_oe_o[i] = dir[i] & ~drive_val[i];
          pad_hd0_o[i] = 1'b1;
        end
      endcase
      pad_pull_up_o[i] = cfg[i].pull == gpcr_pkg::PULL_UP;
      pad_pull_dn_o[i] = cfg[i].pull == gpcr_pkg::PULL_DOWN;
    end
  end

  // wake signal, direct or latched
  assign wake = wake_sel ? |match_rec : |detect;
  assign wake_o = wake;
  assign irq_o = |(irq_status & irq_mask);

  // bus handshake
  assign hreadyout_o = ~rd_wait;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata;
  assign addr_take = hsel_i & hready_i & htrans_i == gpcr_pkg::HTRANS_NONSEQ;

  // interrupt register strobes
  assign mask_wr = dp_wr & (dp_req.addr == gpcr_pkg::OFF_IRQ_MASK);
  assign status_rd = dp_rd & rd_wait & (dp_req.addr == gpcr_pkg::OFF_IRQ_STATUS);

  // address phase capture
  always_comb begin
    next_dp_req = dp_req;
    next_dp_wr = 1'b0;
    next_dp_rd = 1'b0;
    next_rd_wait = 1'b0;
    if (addr_take) begin
      next_dp_req.addr = haddr_i[11:0];
      next_dp_req.write = hwrite_i;
      next_dp_wr = hwrite_i;
      next_dp_rd = ~hwrite_i;
      next_rd_wait = ~hwrite_i;
    end
  end

  // bus phase registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dp_req <= '0;
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      rd_wait <= 1'b0;
    end else begin
      dp_req <= next_dp_req;
      dp_wr <= next_dp_wr;
      dp_rd <= next_dp_rd;
      rd_wait <= next_rd_wait;
    end
  end

  // sticky events, set wins over read clear
  always_comb begin
    logic [1:0] ev;
    ev = 2'h0;
    ev[gpcr_pkg::IRQ_WAKE_BIT] = wake & ~wake_q;
    ev[gpcr_pkg::IRQ_MATCH_BIT] = |(detect & ~match_rec);
    next_wake_q = wake;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (mask_wr) begin
      next_irq_mask = hwdata_i[1:0];
    end
    if (status_rd) begin
      next_irq_status = 2'h0;
    end
    next_irq_status = next_irq_status | ev;
  end

  // interrupt registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      wake_q <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      wake_q <= next_wake_q;
    end
  end

  // next state of the port registers
  always_comb begin
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    a = dp_req.addr;
    w = hwdata_i;
    r = gpcr_pkg::RST_WORD;
    next_drive_val = drive_val;
    next_dir = dir;
    next_wake_sel = wake_sel;
    next_cfg = cfg;
    next_rdata = rdata;
    next_match_rec = match_rec;
    // write data phase
    if (dp_wr && dp_req.write) begin
      unique case (a)
        gpcr_pkg::OFF_DRIVE_VAL: begin
          next_drive_val = w;
        end
        gpcr_pkg::OFF_DRIVE_SET: begin
          next_drive_val = drive_val | w;
        end
        gpcr_pkg::OFF_DRIVE_CLR: begin
          next_drive_val = drive_val & ~w;
        end
        gpcr_pkg::OFF_DIR: begin
          next_dir = w;
        end
        gpcr_pkg::OFF_DIR_SET: begin
          next_dir = dir | w;
        end
        gpcr_pkg::OFF_DIR_CLR: begin
          next_dir = dir & ~w;
        end
        gpcr_pkg::OFF_MATCH: begin
          next_match_rec = match_rec & ~w;
        end
        gpcr_pkg::OFF_WAKE_SEL: begin
          next_wake_sel = w[0];
        end
        default: begin
          if (is_cfg(a)) begin
            next_cfg[cfg_idx(a)] = word_cfg(w);
            next_dir[cfg_idx(a)] = w[gpcr_pkg::CFG_DIR_BIT];
          end
        end
      endcase
    end
    // read data, one wait state
    if (dp_rd && rd_wait) begin
      unique case (a)
        gpcr_pkg::OFF_DRIVE_VAL,
        gpcr_pkg::OFF_DRIVE_SET,
        gpcr_pkg::OFF_DRIVE_CLR: begin
          r = drive_val;
        end
        gpcr_pkg::OFF_SAMPLED: begin
          r = level;
        end
        gpcr_pkg::OFF_DIR,
        gpcr_pkg::OFF_DIR_SET,
        gpcr_pkg::OFF_DIR_CLR: begin
          r = dir;
        end
        gpcr_pkg::OFF_MATCH: begin
          r = match_rec;
        end
        gpcr_pkg::OFF_WAKE_SEL: begin
          r[0] = wake_sel;
        end
        gpcr_pkg::OFF_IRQ_STATUS: begin
          r[1:0] = irq_status;
        end
        gpcr_pkg::OFF_IRQ_MASK: begin
          r[1:0] = irq_mask;
        end
        default: begin
          if (is_cfg(a)) begin
            r = cfg_word(cfg[cfg_idx(a)], dir[cfg_idx(a)]);
          end
        end
      endcase
      next_rdata = r;
    end
    // level-match capture, set wins over clear
    next_match_rec = next_match_rec | detect;
  end

  // register update
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      drive_val <= gpcr_pkg::RST_WORD;
      dir <= gpcr_pkg::RST_WORD;
      match_rec <= gpcr_pkg::RST_WORD;
      wake_sel <= 1'b0;
      for (int i = 0; i < NPIN; i++) begin
        cfg[i] <= gpcr_pkg::RST_CFG;
      end
      rdata <= gpcr_pkg::RST_WORD;
    end else begin
      drive_val <= next_drive_val;
      dir <= next_dir;
      match_rec <= next_match_rec;
      wake_sel <= next_wake_sel;
      cfg <= next_cfg;
      rdata <= next_rdata;
    end
  end

endmodule : gpcr_top

/* verification/gpcr_pad_model.sv */
// Purpose: pads and outside wiring of the 32 port pins
// Assumes: levels change just after the rising clock edge
// Notes: a floating pin toggles every cycle
module gpcr_pad_model #(
  parameter int NPIN = 32
) (
  input  wire logic            mclk_i,
  input  wire logic [NPIN-1:0] pad_out_i,
  input  wire logic [NPIN-1:0] pad_oe_i,
  input  wire logic [NPIN-1:0] pad_pull_up_i,
  input  wire logic [NPIN-1:0] pad_pull_dn_i,
  output logic      [NPIN-1:0] pad_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NPIN-1:0] next_pad_lvl;
  initial pad_lvl_o = '0;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe_i[i]) next_pad_lvl[i] = pad_out_i[i];
      else if (pad_pull_up_i[i]) next_pad_lvl[i] = 1'b1;
      else if (pad_pull_dn_i[i]) next_pad_lvl[i] = 1'b0;
      else next_pad_lvl[i] = ~pad_lvl_o[i];
    end
  end
  always @(posedge mclk_i) pad_lvl_o <= next_pad_lvl;
endmodule : gpcr_pad_model

/* verification/gpcr_top_assertions.sv */
// Purpose: bus and pad checks of the gpio port registers
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every gpcr_top
module gpcr_top_assertions #(
  parameter int NPIN = 32
) (
  input  wire logic            mclk_i,
  input  wire logic            srst_i,
  input  wire logic            hsel_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [31:0]     hwdata_i,
  input  wire logic            hready_i,
  input  wire logic            hreadyout_o,
  input  wire logic            hresp_o,
  input  wire logic [31:0]     hrdata_o,
  input  wire logic [NPIN-1:0] pad_in_i,
  input  wire logic [NPIN-1:0] pad_out_o,
  input  wire logic [NPIN-1:0] pad_oe_o,
  input  wire logic [NPIN-1:0] pad_in_en_o,
  input  wire logic [NPIN-1:0] pad_pull_up_o,
  input  wire logic [NPIN-1:0] pad_pull_dn_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel_i && hready_i && htrans_i == 2'h2 && !hwrite_i;
  assign wr_take = hsel_i && hready_i && htrans_i == 2'h2 && hwrite_i;
  a_read_wait: assert property (rd_take |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_take |=> hreadyout_o)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp_o)
    else $error("error response");
  a_rdata_hold: assert property (!$stable(hrdata_o) |-> !$past(hreadyout_o))
    else $error("read data moved");
  a_clear_low: assert property (wr_take && haddr_i[11:0] == 12'h50C |=> ##1
    (pad_out_o & $past(hwdata_i)) == '0 &&
    (pad_out_o & ~$past(hwdata_i)) == ($past(pad_out_o) & ~$past(hwdata_i)))
    else $error("drive clear wrong");
  a_clear_read: assert property (
    rd_take && haddr_i[11:0] == 12'h50C |=> ##1 hrdata_o == pad_out_o)
    else $error("drive clear read wrong");
  a_sampled_read: assert property (rd_take && haddr_i[11:0] == 12'h510
    ##1 $stable(pad_in_i & pad_in_en_o) [*2] |-> hrdata_o == (pad_in_i & pad_in_en_o))
    else $error("sampled levels wrong");
  a_pull_excl: assert property ((pad_pull_up_o & pad_pull_dn_o) == '0)
    else $error("both pulls on");
  a_reset_pads: assert property ($fell(srst_i) |-> pad_oe_o == '0 &&
    pad_in_en_o == '0)
    else $error("pads not idle after reset");
  c_read_in: cover property (rd_take && haddr_i[11:0] == 12'h510);
  c_clear: cover property (wr_take && haddr_i[11:0] == 12'h50C);
  c_pull_dn: cover property (pad_pull_dn_o != '0);
endmodule : gpcr_top_assertions

bind gpcr_top gpcr_top_assertions #(.NPIN(NPIN)) u_chk (
  .mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_in_en_o(pad_in_en_o),
  .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o));

/* verification/gpcr_top_tb.sv */
// Purpose: self-checking bench of the gpio port registers
// Assumes: one AHB-Lite master, pad model on every pin
// Notes: expectations come from the register map
module gpcr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = '0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = '0;
  logic        hreadyout_o, hresp_o, wake_o, irq_o;
  logic [31:0] hrdata_o, pad_in_i, pad_out_o, pad_oe_o, pad_in_en_o;
  logic [31:0] pad_hd0_o, pad_hd1_o, pad_pull_up_o, pad_pull_dn_o, rd;
  logic [11:0] zr[7] = '{12'h50C, 12'h510, 12'h514, 12'h518, 12'h51C, 12'h524, 12'h530};
  int          n_mismatch = 0;
  int          compares = 0;

  always #50 mclk_i = ~mclk_i;

  gpcr_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pad_in_en_o(pad_in_en_o), .pad_hd0_o(pad_hd0_o), .pad_hd1_o(pad_hd1_o),
    .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o), .wake_o(wake_o),
    .irq_o(irq_o));
  gpcr_pad_model u_pads (.mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pad_pull_up_i(pad_pull_up_o), .pad_pull_dn_i(pad_pull_dn_o), .pad_lvl_o(pad_in_i));

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 16);
    check({31'h0, hreadyout_o}, 32'h1);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= gpcr_pkg::HTRANS_NONSEQ;
    hwrite_i <= w;
    haddr_i <= {20'h0, a};
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata_o;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(posedge mclk_i);
  endtask : wr

  task automatic chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : chk

  initial begin
    #400000;
    n_mismatch++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    foreach (zr[i]) chk(zr[i], 32'h0);
    for (int n = 0; n < 32; n++) chk(12'h700 + 12'(4 * n), 32'h2);
    check(pad_oe_o | pad_in_en_o, 32'h0);
    $display("test reset done");
    wr(12'h504, 32'hA5A5_0F0F);
    wr(12'h50C, 32'h0000_0F00);
    chk(12'h50C, 32'hA5A5_000F);
    check(pad_out_o, 32'hA5A5_000F);
    wr(12'h508, 32'h0000_0030);
    chk(12'h50C, 32'hA5A5_003F);
    $display("test drive clear done");
    wr(12'h514, 32'hF0);
    wr(12'h518, 32'h03);
    chk(12'h514, 32'hF3);
    chk(12'h518, 32'hF3);
    wr(12'h51C, 32'h10);
    chk(12'h51C, 32'hE3);
    check(pad_oe_o, 32'hE3);
    $display("test direction done");
    wr(12'h70C, 32'hC);
    chk(12'h510, 32'h8);
    wr(12'h510, 32'hFFFF_FFFF);
    chk(12'h510, 32'h8);
    wr(12'h70C, 32'h4);
    chk(12'h510, 32'h0);
    check(pad_pull_dn_o | pad_pull_up_o, 32'h8);
    $display("test input done");
    for (int c = 0; c < 8; c++) begin
      wr(12'h720, {21'h0, 3'(c), 8'h03});
      check({29'h0, pad_hd0_o[8], pad_hd1_o[8], pad_oe_o[8]},
        {29'h0, c == 1 || c == 3 || c == 7, c == 2 || c == 3 || c == 5, c < 4 || c > 5});
      chk(12'h720, {21'h0, 3'(c), 8'h03});
    end
    $display("test drive codes done");
    wr(12'h604, 32'h3);
    chk(12'h604, 32'h3);
    wr(12'h70C, 32'h0003_0004);
    repeat (2) @(posedge mclk_i);
    check({30'h0, wake_o, irq_o}, 32'h3);
    chk(12'h520, 32'h8);
    chk(12'h600, 32'h3);
    chk(12'h600, 32'h0);
    wr(12'h70C, 32'h4);
    wr(12'h604, 32'h0);
    check({30'h0, wake_o, irq_o}, 32'h0);
    chk(12'h520, 32'h8);
    wr(12'h524, 32'h1);
    chk(12'h524, 32'h1);
    check({30'h0, wake_o, irq_o}, 32'h2);
    wr(12'h604, 32'h3);
    check({31'h0, irq_o}, 32'h1);
    chk(12'h600, 32'h1);
    wr(12'h520, 32'h8);
    chk(12'h520, 32'h0);
    check({30'h0, wake_o, irq_o}, 32'h0);
    wr(12'h70C, 32'h0002_000C);
    chk(12'h520, 32'h8);
    $display("test sensing done");
    print_verdict();
  end
endmodule : gpcr_top_tb
